// File: hdl/wspl_pstate.sv
`timescale 1ns/1ps
module wspl_pstate
    import wspl_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_reset,
    wspl_pm_if.fsm    pm
);
    typedef struct packed {
        wspl_pstate_e st;
        logic         warm_seen;
    } wspl_pstate_s;

    wspl_pstate_s state_reg;
    wspl_pstate_s state_next;

    always_comb
    begin
        state_next           = state_reg;
        state_next.warm_seen = pm.warm_reset;
        case (state_reg.st)
            WSPL_ST_D0_UNINIT:
            begin
                if (pm.io_en && pm.mem_en)
                    state_next.st = WSPL_ST_D0_ACTIVE;
            end
            WSPL_ST_D3_COLD:
            begin
                if (state_reg.warm_seen && !pm.warm_reset)
                    state_next.st = WSPL_ST_D0_UNINIT;
            end
            default:
            begin
            end
        endcase
        if (pm.field_wr && state_reg.st != WSPL_ST_D3_COLD)
        begin
            case (pm.field_wdata)
                WSPL_PS_D1: state_next.st = WSPL_ST_D1;
                WSPL_PS_D2: state_next.st = WSPL_ST_D2;
                WSPL_PS_D3: state_next.st = WSPL_ST_D3_HOT;
                default:    state_next.st = (state_reg.st == WSPL_ST_D0_UNINIT) ? WSPL_ST_D0_UNINIT
                                                                               : WSPL_ST_D0_ACTIVE;
            endcase
        end
        // bus reset while in d3hot means main power went away
        if (pm.warm_reset)
            state_next.st = (state_reg.st == WSPL_ST_D3_HOT || state_reg.st == WSPL_ST_D3_COLD)
                            ? WSPL_ST_D3_COLD : WSPL_ST_D0_UNINIT;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            state_reg.st        <= WSPL_ST_D0_UNINIT;
            state_reg.warm_seen <= 1'b0;
        end
        else
            state_reg <= state_next;
    end

    always_comb
    begin
        case (state_reg.st)
            WSPL_ST_D1:      pm.power_state_field = WSPL_PS_D1;
            WSPL_ST_D2:      pm.power_state_field = WSPL_PS_D2;
            WSPL_ST_D3_HOT,
            WSPL_ST_D3_COLD: pm.power_state_field = WSPL_PS_D3;
            default:         pm.power_state_field = WSPL_PS_D0;
        endcase
    end

    assign pm.uninit  = (state_reg.st == WSPL_ST_D0_UNINIT);
    assign pm.d3_cold = (state_reg.st == WSPL_ST_D3_COLD);
endmodule : wspl_pstate

// File: hdl/wspl_sync.sv
`timescale 1ns/1ps
module wspl_sync
    import wspl_pkg::*;
#(
    parameter int WIDTH = 3
)(
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    if (WIDTH < 1)
    begin : g_bad_width
        $error("wspl_sync: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } wspl_sync_s;

    wspl_sync_s state_reg;
    wspl_sync_s state_next;

    always_comb
    begin
        state_next        = state_reg;
        state_next.stage1 = i_async;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign o_sync = state_reg.stage2;
endmodule : wspl_sync

// File: hdl/wspl_top.sv
`timescale 1ns/1ps
module wspl_top
    import wspl_pkg::*;
#(
    parameter logic [15:0] PM_CAPS_BRIDGE = 16'h0002, // capability word, value arbitrary
    parameter logic [15:0] PM_CAPS_SMART  = 16'h0002  // capability word, value arbitrary
)(
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_warm_bus_reset,
    input  wire logic        i_card_ring_n,
    input  wire logic        i_card_wake_request,
    input  wire logic        i_card_is_16bit,
    input  wire logic        i_card_powered,
    input  wire logic        i_ring_source_enable,
    input  wire logic        i_status_change_mask,
    input  wire logic        i_ring_alt_pin_four,
    input  wire logic        i_cfg_func,
    input  wire logic        i_cfg_rd,
    input  wire logic        i_cfg_wr,
    input  wire logic [7:0]  i_cfg_addr,
    input  wire logic [3:0]  i_cfg_be,
    input  wire logic [31:0] i_cfg_wdata,
    output logic [31:0]      o_cfg_rdata,
    output logic             o_cfg_ack,
    output logic             o_ring_wake_output_n,
    output logic             o_multipurpose_pin_two_n,
    output logic             o_multipurpose_pin_four_n,
    output logic [1:0]       o_bus_power_state
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (WSPL_BIT_CAP_LIST > 31 || WSPL_BIT_RING_OUT_EN > 31 || WSPL_BIT_WAKE_STATUS > 31)
    begin : g_bad_field
        $error("wspl_top: field position outside the configuration word");
    end

    // ------------------------------------------------------------
    // pin synchronisers and power state tracker
    // ------------------------------------------------------------
    // synchroniser lanes: warm reset, ring, card wake
    localparam int PIN_COUNT = 3;
    localparam int PIN_WARM  = 2;
    localparam int PIN_RING  = 1;
    localparam int PIN_WAKE  = 0;

    logic [PIN_COUNT-1:0] pins_sync;
    logic                 warm_s;
    logic                 ring_s;
    logic                 wake_s;

    wspl_sync #(.WIDTH(PIN_COUNT)) u_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async ({i_warm_bus_reset, ~i_card_ring_n, i_card_wake_request}),
        .o_sync  (pins_sync)
    );
    assign warm_s = pins_sync[PIN_WARM];
    assign ring_s = pins_sync[PIN_RING];
    assign wake_s = pins_sync[PIN_WAKE];

    wspl_pm_if pm ();

    wspl_pstate u_pstate (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .pm      (pm)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        io_en;
        logic        mem_en;
        logic        pin_select;
        logic        ring_out_en;
        logic        wake_en;
        logic        wake_status;
        logic        sc_io_en;
        logic        sc_mem_en;
        logic        sc_d3;
        logic        sc_wake_en;
        logic        sc_wake_status;
        logic [31:0] rdata;
        logic        ack;
        logic        ring_pin_n;
        logic        two_n;
        logic        four_n;
        logic [1:0]  bus_state;
    } wspl_top_s;

    wspl_top_s state_reg;
    wspl_top_s state_next;

    logic        src_ring16;
    logic        src_cb_wake;
    logic        src_cb_change;
    logic        ring_active;
    logic        wake_active;
    logic        sc_wake_active;
    logic        acc_bridge;
    logic [31:0] rd_word;
    logic        wr_b0;
    logic        wr_b1;

    // ------------------------------------------------------------
    // wake sources
    // ------------------------------------------------------------
    assign src_ring16    = i_card_is_16bit && i_card_powered && ring_s && i_ring_source_enable;
    assign src_cb_wake   = !i_card_is_16bit && !i_card_powered && wake_s && i_status_change_mask;
    assign src_cb_change = !i_card_is_16bit && i_card_powered && wake_s && i_status_change_mask;
    assign ring_active   = state_reg.ring_out_en && (src_ring16 || src_cb_wake || src_cb_change);
    assign wake_active   = state_reg.wake_en && state_reg.wake_status && !pm.uninit;
    assign sc_wake_active = state_reg.sc_wake_en && state_reg.sc_wake_status;

    // ------------------------------------------------------------
    // configuration read decode
    // ------------------------------------------------------------
    assign acc_bridge = (i_cfg_func == WSPL_FUNC_BRIDGE);
    assign wr_b0      = i_cfg_wr && i_cfg_be[0];
    assign wr_b1      = i_cfg_wr && i_cfg_be[1];

    always_comb
    begin
        rd_word = WSPL_ZERO_WORD;
        if (i_cfg_addr == WSPL_OFS_CMD_STATUS)
        begin
            rd_word[WSPL_BIT_CAP_LIST] = 1'b1;
            rd_word[WSPL_BIT_IO_EN]    = acc_bridge ? state_reg.io_en : state_reg.sc_io_en;
            rd_word[WSPL_BIT_MEM_EN]   = acc_bridge ? state_reg.mem_en : state_reg.sc_mem_en;
        end
        else if (acc_bridge)
        begin
            case (i_cfg_addr)
                WSPL_OFS_CAP_PTR:   rd_word[7:0] = WSPL_OFS_BR_PM_HDR;
                WSPL_OFS_SYS_CTRL:  rd_word[WSPL_BIT_PIN_SELECT] = state_reg.pin_select;
                WSPL_OFS_CARD_CTRL: rd_word[WSPL_BIT_RING_OUT_EN] = state_reg.ring_out_en;
                WSPL_OFS_BR_PM_HDR: rd_word = {PM_CAPS_BRIDGE, WSPL_NEXT_NONE, WSPL_PM_CAP_ID};
                WSPL_OFS_BR_BRIDGE_PM_CONTROL_STATUS_BLOCK:
                begin
                    rd_word[WSPL_BIT_WAKE_STATUS]            = state_reg.wake_status;
                    rd_word[WSPL_BIT_WAKE_EN]                = state_reg.wake_en;
                    rd_word[WSPL_FLD_STATE_LO +: 2]          = pm.power_state_field;
                end
                default:            rd_word = WSPL_ZERO_WORD;
            endcase
        end
        else
        begin
            case (i_cfg_addr)
                WSPL_OFS_SC_PM_HDR: rd_word = {PM_CAPS_SMART, WSPL_NEXT_NONE, WSPL_PM_CAP_ID};
                WSPL_OFS_SC_BRIDGE_PM_CONTROL_STATUS_BLOCK:
                begin
                    rd_word[WSPL_BIT_WAKE_STATUS]   = state_reg.sc_wake_status;
                    rd_word[WSPL_BIT_WAKE_EN]       = state_reg.sc_wake_en;
                    rd_word[WSPL_FLD_STATE_LO +: 2] = state_reg.sc_d3 ? WSPL_PS_D3 : WSPL_PS_D0;
                end
                default:            rd_word = WSPL_ZERO_WORD;
            endcase
        end
    end

    // ------------------------------------------------------------
    // power tracker hookup
    // ------------------------------------------------------------
    assign pm.io_en       = state_reg.io_en;
    assign pm.mem_en      = state_reg.mem_en;
    assign pm.warm_reset  = warm_s;
    assign pm.field_wr    = wr_b0 && acc_bridge && (i_cfg_addr == WSPL_OFS_BR_BRIDGE_PM_CONTROL_STATUS_BLOCK);
    assign pm.field_wdata = i_cfg_wdata[WSPL_FLD_STATE_LO +: 2];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_next       = state_reg;
        state_next.ack   = i_cfg_rd || i_cfg_wr;
        state_next.rdata = i_cfg_rd ? rd_word : WSPL_ZERO_WORD;

        if (wr_b0 && i_cfg_addr == WSPL_OFS_CMD_STATUS)
        begin
            if (acc_bridge)
            begin
                state_next.io_en  = i_cfg_wdata[WSPL_BIT_IO_EN];
                state_next.mem_en = i_cfg_wdata[WSPL_BIT_MEM_EN];
            end
            else
            begin
                state_next.sc_io_en  = i_cfg_wdata[WSPL_BIT_IO_EN];
                state_next.sc_mem_en = i_cfg_wdata[WSPL_BIT_MEM_EN];
            end
        end
        if (acc_bridge)
        begin
            if (wr_b0 && i_cfg_addr == WSPL_OFS_SYS_CTRL)
                state_next.pin_select = i_cfg_wdata[WSPL_BIT_PIN_SELECT];
            if (wr_b1 && i_cfg_addr == WSPL_OFS_CARD_CTRL)
                state_next.ring_out_en = i_cfg_wdata[WSPL_BIT_RING_OUT_EN];
            if (wr_b1 && i_cfg_addr == WSPL_OFS_BR_BRIDGE_PM_CONTROL_STATUS_BLOCK)
            begin
                state_next.wake_en = i_cfg_wdata[WSPL_BIT_WAKE_EN];
                if (i_cfg_wdata[WSPL_BIT_WAKE_STATUS])
                    state_next.wake_status = 1'b0;
            end
        end
        else if (i_cfg_addr == WSPL_OFS_SC_BRIDGE_PM_CONTROL_STATUS_BLOCK)
        begin
            // d1 and d2 codes are not supported and leave the state alone
            if (wr_b0 && i_cfg_wdata[WSPL_FLD_STATE_LO +: 2] == WSPL_PS_D0)
                state_next.sc_d3 = 1'b0;
            if (wr_b0 && i_cfg_wdata[WSPL_FLD_STATE_LO +: 2] == WSPL_PS_D3)
                state_next.sc_d3 = 1'b1;
            if (wr_b1)
            begin
                state_next.sc_wake_en = i_cfg_wdata[WSPL_BIT_WAKE_EN];
                if (i_cfg_wdata[WSPL_BIT_WAKE_STATUS])
                    state_next.sc_wake_status = 1'b0;
            end
        end

        // warm reset clears command bits; bridge wake status only when not armed, smart card wake status never
        if (warm_s)
        begin
            state_next.io_en     = 1'b0;
            state_next.mem_en    = 1'b0;
            state_next.sc_io_en  = 1'b0;
            state_next.sc_mem_en = 1'b0;
            if (!state_reg.wake_en)
                state_next.wake_status = 1'b0;
        end

        // hardware set wins over software clear
        if ((src_ring16 || src_cb_wake || src_cb_change) && !pm.uninit)
            state_next.wake_status = 1'b1;

        // pin routing
        if (!state_reg.pin_select)
        begin
            // ring owns the combined pin whenever it is enabled, so wake events never show there
            if (state_reg.ring_out_en)
                state_next.ring_pin_n = !ring_active;
            else
                state_next.ring_pin_n = !(wake_active || sc_wake_active);
            state_next.two_n      = 1'b1;
            state_next.four_n     = 1'b1;
        end
        else
        begin
            state_next.ring_pin_n = !(wake_active || sc_wake_active);
            state_next.two_n      = !(ring_active && !i_ring_alt_pin_four);
            state_next.four_n     = !(ring_active && i_ring_alt_pin_four);
        end

        state_next.bus_state = pm.power_state_field;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            state_reg            <= '0;
            state_reg.ring_pin_n <= 1'b1;
            state_reg.two_n      <= 1'b1;
            state_reg.four_n     <= 1'b1;
        end
        else
            state_reg <= state_next;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_cfg_rdata               = state_reg.rdata;
    assign o_cfg_ack                 = state_reg.ack;
    assign o_ring_wake_output_n      = state_reg.ring_pin_n;
    assign o_multipurpose_pin_two_n  = state_reg.two_n;
    assign o_multipurpose_pin_four_n = state_reg.four_n;
    assign o_bus_power_state         = state_reg.bus_state;
endmodule : wspl_top

// File: pkg/wspl_pkg.sv
package wspl_pkg;
    // ------------------------------------------------------------
    // configuration offsets
    // ------------------------------------------------------------
    localparam logic [7:0] WSPL_OFS_CMD_STATUS = 8'h04;
    localparam logic [7:0] WSPL_OFS_CAP_PTR    = 8'h14;
    localparam logic [7:0] WSPL_OFS_SYS_CTRL   = 8'h80;
    localparam logic [7:0] WSPL_OFS_CARD_CTRL  = 8'h90;
    localparam logic [7:0] WSPL_OFS_BR_PM_HDR  = 8'hA0;
    localparam logic [7:0] WSPL_OFS_BR_BRIDGE_PM_CONTROL_STATUS_BLOCK  = 8'hA4;
    localparam logic [7:0] WSPL_OFS_SC_PM_HDR  = 8'h44;
    localparam logic [7:0] WSPL_OFS_SC_BRIDGE_PM_CONTROL_STATUS_BLOCK  = 8'h48;
    // ------------------------------------------------------------
    // field positions within the aligned word
    // ------------------------------------------------------------
    localparam int WSPL_BIT_IO_EN       = 0;
    localparam int WSPL_BIT_MEM_EN      = 1;
    localparam int WSPL_BIT_CAP_LIST    = 20;
    localparam int WSPL_BIT_PIN_SELECT  = 0;
    localparam int WSPL_BIT_RING_OUT_EN = 15;
    localparam int WSPL_BIT_WAKE_EN     = 8;
    localparam int WSPL_BIT_WAKE_STATUS = 15;
    localparam int WSPL_FLD_STATE_LO    = 0;
    // ------------------------------------------------------------
    // constant values
    // ------------------------------------------------------------
    localparam logic [7:0]  WSPL_PM_CAP_ID   = 8'h01;
    localparam logic [7:0]  WSPL_NEXT_NONE   = 8'h00;
    localparam logic [31:0] WSPL_ZERO_WORD   = 32'h0000_0000;
    localparam logic [1:0]  WSPL_PS_D0       = 2'h0;
    localparam logic [1:0]  WSPL_PS_D1       = 2'h1;
    localparam logic [1:0]  WSPL_PS_D2       = 2'h2;
    localparam logic [1:0]  WSPL_PS_D3       = 2'h3;
    localparam logic        WSPL_FUNC_BRIDGE = 1'h0;
    localparam logic        WSPL_FUNC_SMART  = 1'h1;

    typedef enum logic [5:0] {
        WSPL_ST_D0_UNINIT = 6'h01,
        WSPL_ST_D0_ACTIVE = 6'h02,
        WSPL_ST_D1        = 6'h04,
        WSPL_ST_D2        = 6'h08,
        WSPL_ST_D3_HOT    = 6'h10,
        WSPL_ST_D3_COLD   = 6'h20
    } wspl_pstate_e;
endpackage : wspl_pkg

// File: pkg/wspl_pm_if.sv
`timescale 1ns/1ps
interface wspl_pm_if;
    logic       field_wr;
    logic [1:0] field_wdata;
    logic       io_en;
    logic       mem_en;
    logic       warm_reset;
    logic [1:0] power_state_field;
    logic       uninit;
    logic       d3_cold;

    modport ctrl (output field_wr, field_wdata, io_en, mem_en, warm_reset,
                  input  power_state_field, uninit, d3_cold);
    modport fsm  (input  field_wr, field_wdata, io_en, mem_en, warm_reset,
                  output power_state_field, uninit, d3_cold);
endinterface : wspl_pm_if

// File: sim/wspl_sock_model.sv
`timescale 1ns/1ps
module wspl_sock_model (
    input  wire logic i_is_16bit,
    input  wire logic i_powered,
    input  wire logic i_ring,
    input  wire logic i_event,
    output logic      o_card_ring_n,
    output logic      o_card_wake_request,
    output logic      o_card_is_16bit,
    output logic      o_card_powered
);
    // ------
    // socket lines
    // ------
    // ring line rests at its pull-up unless a powered 16-bit modem rings
    assign o_card_ring_n       = !(i_ring && i_is_16bit && i_powered);
    // status change only comes from a card-bus card, powered or not
    assign o_card_wake_request = i_event && !i_is_16bit;
    assign o_card_is_16bit     = i_is_16bit;
    assign o_card_powered      = i_powered;
endmodule : wspl_sock_model

// File: sim/wspl_top_asserts.sv
`timescale 1ns/1ps
module wspl_top_asserts
    import wspl_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic        i_ring_source_enable,
    input wire logic        i_status_change_mask,
    input wire logic        i_cfg_func,
    input wire logic        i_cfg_rd,
    input wire logic        i_cfg_wr,
    input wire logic [7:0]  i_cfg_addr,
    input wire logic [31:0] o_cfg_rdata,
    input wire logic        o_cfg_ack,
    input wire logic        o_ring_wake_output_n,
    input wire logic        o_multipurpose_pin_two_n,
    input wire logic        o_multipurpose_pin_four_n,
    input wire logic [1:0]  o_bus_power_state
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // ------
    // config answers and pins
    // ------
    sequence s_rd(logic [7:0] a, logic f);
        i_cfg_rd && i_cfg_addr == a && i_cfg_func == f;
    endsequence
    property p_ack;
        (i_cfg_rd || i_cfg_wr) |=> o_cfg_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("missing ack");
    property p_idle;
        !o_cfg_ack |-> o_cfg_rdata == WSPL_ZERO_WORD;
    endproperty
    a_idle: assert property (p_idle) else $error("read data without ack");
    property p_ptr;
        s_rd(WSPL_OFS_CAP_PTR, WSPL_FUNC_BRIDGE) |=> o_cfg_rdata[7:0] == WSPL_OFS_BR_PM_HDR;
    endproperty
    a_ptr: assert property (p_ptr) else $error("bad capability pointer");
    property p_br_hdr;
        s_rd(WSPL_OFS_BR_PM_HDR, WSPL_FUNC_BRIDGE) |=> o_cfg_rdata[15:0] == {WSPL_NEXT_NONE, WSPL_PM_CAP_ID};
    endproperty
    a_br_hdr: assert property (p_br_hdr) else $error("bad bridge header");
    property p_sc_hdr;
        s_rd(WSPL_OFS_SC_PM_HDR, WSPL_FUNC_SMART) |=> o_cfg_rdata[15:0] == {WSPL_NEXT_NONE, WSPL_PM_CAP_ID};
    endproperty
    a_sc_hdr: assert property (p_sc_hdr) else $error("bad smart card header");
    property p_list;
        i_cfg_rd && i_cfg_addr == WSPL_OFS_CMD_STATUS |=> o_cfg_rdata[WSPL_BIT_CAP_LIST];
    endproperty
    a_list: assert property (p_list) else $error("capability list bit clear");
    property p_reset;
        disable iff (1'b0) i_reset |=> o_ring_wake_output_n && o_multipurpose_pin_two_n
            && o_multipurpose_pin_four_n && o_bus_power_state == WSPL_PS_D0 && !o_cfg_ack;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not at reset value");
    property p_quiet;
        (!i_ring_source_enable && !i_status_change_mask) [*4] |-> o_multipurpose_pin_two_n
            && o_multipurpose_pin_four_n;
    endproperty
    a_quiet: assert property (p_quiet) else $error("ring with sources masked");
endmodule : wspl_top_asserts

bind wspl_top wspl_top_asserts u_asserts (
    .i_clk, .i_reset, .i_ring_source_enable, .i_status_change_mask, .i_cfg_func, .i_cfg_rd,
    .i_cfg_wr, .i_cfg_addr, .o_cfg_rdata, .o_cfg_ack, .o_ring_wake_output_n,
    .o_multipurpose_pin_two_n, .o_multipurpose_pin_four_n, .o_bus_power_state
);

// File: sim/wspl_top_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); \
        end \
    end
module wspl_top_tb
    import wspl_pkg::*;
;
    logic        i_clk = 1'b0, i_reset = 1'b1, i_warm_bus_reset = 1'b0, i_cfg_func = 1'b0;
    logic        i_ring_source_enable = 1'b0, i_status_change_mask = 1'b0, i_ring_alt_pin_four = 1'b0;
    logic        i_cfg_rd = 1'b0, i_cfg_wr = 1'b0, m_is16 = 1'b0, m_pwr = 1'b0, m_ring = 1'b0, m_evt = 1'b0;
    logic        exp_n, i_card_ring_n, i_card_wake_request, i_card_is_16bit, i_card_powered;
    logic        o_cfg_ack, o_ring_wake_output_n, o_multipurpose_pin_two_n, o_multipurpose_pin_four_n;
    logic [7:0]  i_cfg_addr = 8'h00;
    logic [3:0]  i_cfg_be = 4'h0;
    logic [31:0] i_cfg_wdata = 32'h0, rd_data, o_cfg_rdata;
    logic [1:0]  o_bus_power_state;
    int          compares = 0, fail_count = 0;
    // ------
    // design, socket and sequence
    // ------
    always #25 i_clk = ~i_clk;
    wspl_top dut (
        .i_clk, .i_reset, .i_warm_bus_reset, .i_card_ring_n, .i_card_wake_request, .i_card_is_16bit,
        .i_card_powered, .i_ring_source_enable, .i_status_change_mask, .i_ring_alt_pin_four, .i_cfg_func,
        .i_cfg_rd, .i_cfg_wr, .i_cfg_addr, .i_cfg_be, .i_cfg_wdata, .o_cfg_rdata, .o_cfg_ack,
        .o_ring_wake_output_n, .o_multipurpose_pin_two_n, .o_multipurpose_pin_four_n, .o_bus_power_state
    );
    wspl_sock_model u_sock (
        .i_is_16bit(m_is16), .i_powered(m_pwr), .i_ring(m_ring), .i_event(m_evt),
        .o_card_ring_n(i_card_ring_n), .o_card_wake_request(i_card_wake_request),
        .o_card_is_16bit(i_card_is_16bit), .o_card_powered(i_card_powered)
    );
    task automatic cfg(input logic w, input logic f, input logic [7:0] a, input logic [3:0] b,
                       input logic [31:0] d);
        @(negedge i_clk);
        {i_cfg_rd, i_cfg_wr, i_cfg_func, i_cfg_addr, i_cfg_be, i_cfg_wdata} = {!w, w, f, a, b, d};
        @(negedge i_clk);
        {i_cfg_rd, i_cfg_wr} = 2'h0;
        rd_data = o_cfg_rdata;
        `CHK(o_cfg_ack, 1'b1)
    endtask : cfg
    task automatic rd_chk(input logic f, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        cfg(1'b0, f, a, 4'h0, 32'h0);
        `CHK(rd_data & m, e)
    endtask : rd_chk
    task automatic settle;
        repeat (3) @(negedge i_clk);
    endtask : settle
    task automatic src(input logic [6:0] c);
        {m_is16, m_pwr, i_ring_source_enable, i_status_change_mask, m_ring, m_evt, exp_n} = c;
        settle();
    endtask : src
    task automatic wait_bus(input logic [1:0] v);
        int n;
        n = 0;
        while (o_bus_power_state !== v && n < 20)
        begin
            @(negedge i_clk);
            n++;
        end
        `CHK(o_bus_power_state, v)
        if (o_bus_power_state !== v)
            stop_test();
    endtask : wait_bus
    task automatic t_caps;
        rd_chk(1'b0, WSPL_OFS_CMD_STATUS, 32'h0010_0000, 32'h0010_0000);
        rd_chk(1'b0, WSPL_OFS_CAP_PTR, 32'h0000_00FF, 32'h0000_00A0);
        rd_chk(1'b0, WSPL_OFS_BR_PM_HDR, 32'h0000_FFFF, 32'h0000_0001);
        rd_chk(1'b1, WSPL_OFS_SC_PM_HDR, 32'h0000_FFFF, 32'h0000_0001);
        rd_chk(1'b0, 8'hFC, 32'hFFFF_FFFF, 32'h0);
    endtask : t_caps
    task automatic t_state;
        for (int s = 0; s < 4; s++)
        begin
            cfg(1'b1, 1'b0, WSPL_OFS_BR_BRIDGE_PM_CONTROL_STATUS_BLOCK, 4'h1, 32'(s));
            rd_chk(1'b0, WSPL_OFS_BR_BRIDGE_PM_CONTROL_STATUS_BLOCK, 32'h3, 32'(s));
            `CHK(o_bus_power_state, 2'(s))
        end
        cfg(1'b1, 1'b0, WSPL_OFS_BR_BRIDGE_PM_CONTROL_STATUS_BLOCK, 4'h1, 32'h0);
        for (int s = 1; s < 4; s++)
        begin
            cfg(1'b1, 1'b1, WSPL_OFS_SC_BRIDGE_PM_CONTROL_STATUS_BLOCK, 4'h1, 32'(s));
            rd_chk(1'b1, WSPL_OFS_SC_BRIDGE_PM_CONTROL_STATUS_BLOCK, 32'h3, (s == 3) ? 32'h3 : 32'h0);
        end
        cfg(1'b1, 1'b1, WSPL_OFS_SC_BRIDGE_PM_CONTROL_STATUS_BLOCK, 4'h1, 32'h0);
    endtask : t_state
    task automatic t_ring;
        logic [6:0] tbl [6] = '{7'h74, 7'h6D, 7'h2A, 7'h33, 7'h0A, 7'h01};
        cfg(1'b1, 1'b0, WSPL_OFS_CMD_STATUS, 4'h1, 32'h3);
        cfg(1'b1, 1'b0, WSPL_OFS_CARD_CTRL, 4'h2, 32'h8000);
        foreach (tbl[k])
        begin
            src(tbl[k]);
            `CHK(o_ring_wake_output_n, exp_n)
        end
        src(7'h74);
        cfg(1'b1, 1'b0, WSPL_OFS_CARD_CTRL, 4'h2, 32'h0);
        settle();
        `CHK(o_ring_wake_output_n, 1'b1)
    endtask : t_ring
    task automatic t_route;
        cfg(1'b1, 1'b0, WSPL_OFS_CARD_CTRL, 4'h2, 32'h8000);
        cfg(1'b1, 1'b0, WSPL_OFS_SYS_CTRL, 4'h1, 32'h1);
        cfg(1'b1, 1'b0, WSPL_OFS_BR_BRIDGE_PM_CONTROL_STATUS_BLOCK, 4'h2, 32'h0100);
        for (int p = 0; p < 2; p++)
        begin
            i_ring_alt_pin_four = p[0];
            src(7'h74);
            `CHK({o_multipurpose_pin_four_n, o_multipurpose_pin_two_n}, p[0] ? 2'h1 : 2'h2)
            `CHK(o_ring_wake_output_n, 1'b0)
        end
        src(7'h01);
        cfg(1'b1, 1'b0, WSPL_OFS_BR_BRIDGE_PM_CONTROL_STATUS_BLOCK, 4'h2, 32'h8100);
        settle();
        `CHK(o_ring_wake_output_n, 1'b1)
        cfg(1'b1, 1'b0, WSPL_OFS_SYS_CTRL, 4'h1, 32'h0);
        src(7'h2A);
        src(7'h01);
        rd_chk(1'b0, WSPL_OFS_BR_BRIDGE_PM_CONTROL_STATUS_BLOCK, 32'h8100, 32'h8100);
        `CHK(o_ring_wake_output_n, 1'b1)
        cfg(1'b1, 1'b0, WSPL_OFS_CARD_CTRL, 4'h2, 32'h0);
        settle();
        `CHK(o_ring_wake_output_n, 1'b0)
    endtask : t_route
    task automatic t_warm;
        cfg(1'b1, 1'b0, WSPL_OFS_BR_BRIDGE_PM_CONTROL_STATUS_BLOCK, 4'h1, 32'h3);
        i_warm_bus_reset = 1'b1;
        repeat (2) settle();
        `CHK(o_bus_power_state, 2'h3)
        i_warm_bus_reset = 1'b0;
        wait_bus(2'h0);
        rd_chk(1'b0, WSPL_OFS_BR_BRIDGE_PM_CONTROL_STATUS_BLOCK, 32'h8100, 32'h8100);
        rd_chk(1'b0, WSPL_OFS_CMD_STATUS, 32'h3, 32'h0);
        cfg(1'b1, 1'b0, WSPL_OFS_SYS_CTRL, 4'h1, 32'h1);
        settle();
        `CHK(o_ring_wake_output_n, 1'b1)
        cfg(1'b1, 1'b0, WSPL_OFS_CMD_STATUS, 4'h1, 32'h3);
        settle();
        `CHK(o_ring_wake_output_n, 1'b0)
        cfg(1'b1, 1'b0, WSPL_OFS_BR_BRIDGE_PM_CONTROL_STATUS_BLOCK, 4'h2, 32'h0);
        i_warm_bus_reset = 1'b1;
        settle();
        i_warm_bus_reset = 1'b0;
        settle();
        rd_chk(1'b0, WSPL_OFS_BR_BRIDGE_PM_CONTROL_STATUS_BLOCK, 32'h8000, 32'h0);
    endtask : t_warm
    task automatic t_global;
        cfg(1'b1, 1'b0, WSPL_OFS_BR_BRIDGE_PM_CONTROL_STATUS_BLOCK, 4'h1, 32'h2);
        wait_bus(2'h2);
        i_reset = 1'b1;
        @(negedge i_clk);
        `CHK(o_bus_power_state, 2'h0)
        i_reset = 1'b0;
        rd_chk(1'b0, WSPL_OFS_BR_BRIDGE_PM_CONTROL_STATUS_BLOCK, 32'h8103, 32'h0);
    endtask : t_global
    task automatic stop_test;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (12) @(negedge i_clk);
        i_reset = 1'b0;
        t_caps();
        t_state();
        t_ring();
        t_route();
        t_warm();
        t_global();
        stop_test();
    end
endmodule : wspl_top_tb
